// *** verilog/phy_next_page_mmd_regs.sv ***
`timescale 1ns/1ps
// Next-page transmit/partner words, indirect access pair and digital control register
// Notes on behaviour
// - Transmit compliance bit is writable, tells partner we will comply; resets to zero.
// - Transmit toggle bit is read-only, shows toggle of previous transmitted word.
// - Transmit message field is eleven writable bits, reset value one.
// - Partner next-page bit reads one while more pages follow, zero on last.
// - Partner acknowledge bit shows partner received our word; resets to zero.
// - Partner compliance bit shows partner can act on message; resets to zero.
// - Partner toggle bit is read-only and shows received toggle value.
// - Function field selects address, data, data increment both, data increment writes.
// - Set PLL-off bit turns PLL off during energy-detect power-down, else on.
// - PLL-off acts only in energy-detect power-down; reset leaves PLL running.
// - Page-received bit latches high on new partner page until read.
module phy_next_page_mmd_regs (
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    input  wire logic [4:0]  REG_ADDR_I,
    input  wire logic [15:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic [15:0]      REG_RDATA_O,
    output logic             REG_RVALID_O,
    input  wire logic        PAGE_RX_I,
    input  wire logic [15:0] PAGE_RX_WORD_I,
    input  wire logic        TX_TOGGLE_I,
    input  wire logic        ENERGY_DETECT_POWER_DOWN_I,
    output logic [15:0]      NP_TX_WORD_O,
    output logic             PLL_ENABLE_O
);

    phy_np_pkg::reg_req_type req;
    phy_np_pkg::ext_req_type ext_req;
    logic [15:0]             ext_rdata;
    logic                    hit_tx;
    logic                    hit_exp;
    logic                    hit_ctrl;
    logic                    hit_data;
    logic                    hit_dig;

    // A write takes precedence if both strobes arrive together
    assign req = '{wr: REG_WR_I, rd: REG_RD_I && !REG_WR_I, addr: REG_ADDR_I, wdata: REG_WDATA_I};

    assign hit_tx   = (req.addr == phy_np_pkg::OFS_NP_TX);
    assign hit_exp  = (req.addr == phy_np_pkg::OFS_AN_EXPANSION);
    assign hit_ctrl = (req.addr == phy_np_pkg::OFS_IND_CTRL);
    assign hit_data = (req.addr == phy_np_pkg::OFS_IND_DATA);
    assign hit_dig  = (req.addr == phy_np_pkg::OFS_DIG_CTRL);

    // Transmit next-page word
    logic        np_next;
    logic        np_msg_page;
    logic        np_comply;
    logic [10:0] np_msg;
    logic        tx_toggle;
    logic        next_np_next;
    logic        next_np_msg_page;
    logic        next_np_comply;
    logic [10:0] next_np_msg;
    logic        next_tx_toggle;

    always_comb begin
        next_np_next     = np_next;
        next_np_msg_page = np_msg_page;
        next_np_comply   = np_comply;
        next_np_msg      = np_msg;
        // Toggle follows the negotiation engine, never software
        next_tx_toggle   = TX_TOGGLE_I;
        if (req.wr && hit_tx) begin
            next_np_next     = req.wdata[phy_np_pkg::NP_NEXT_BIT];
            next_np_msg_page = req.wdata[phy_np_pkg::NP_MSG_PAGE_BIT];
            next_np_comply   = req.wdata[phy_np_pkg::NP_COMPLY_BIT];
            next_np_msg      = req.wdata[phy_np_pkg::NP_MSG_MSB:0];
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            np_next     <= phy_np_pkg::NP_NEXT_RESET;
            np_msg_page <= phy_np_pkg::NP_MSG_PAGE_RESET;
            np_comply   <= phy_np_pkg::NP_COMPLY_RESET;
            np_msg      <= phy_np_pkg::NP_MSG_RESET;
            tx_toggle   <= phy_np_pkg::TOGGLE_RESET;
        end else begin
            np_next     <= next_np_next;
            np_msg_page <= next_np_msg_page;
            np_comply   <= next_np_comply;
            np_msg      <= next_np_msg;
            tx_toggle   <= next_tx_toggle;
        end
    end

    assign NP_TX_WORD_O = {np_next, 1'h0, np_msg_page, np_comply, tx_toggle, np_msg};

    // Partner next-page word and page-received flag
    logic [15:0] partner;
    logic        page_received;
    logic [15:0] next_partner;
    logic        next_page_received;

    always_comb begin
        next_partner = partner;
        if (PAGE_RX_I) begin
            next_partner = PAGE_RX_WORD_I;
        end
        // A page landing in the reading cycle is kept for the next read
        next_page_received = PAGE_RX_I || (page_received && !(req.rd && hit_exp));
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            partner       <= phy_np_pkg::PARTNER_RESET;
            page_received <= phy_np_pkg::PAGE_FLAG_RESET;
        end else begin
            partner       <= next_partner;
            page_received <= next_page_received;
        end
    end

    // Indirect control and digital control
    logic [15:0] ind_ctrl;
    logic [15:0] dig_ctrl;
    logic [15:0] next_ind_ctrl;
    logic [15:0] next_dig_ctrl;

    always_comb begin
        next_ind_ctrl = ind_ctrl;
        next_dig_ctrl = dig_ctrl;
        if (req.wr && hit_ctrl) begin
            // Reserved middle bits are stored as written
            next_ind_ctrl = req.wdata;
        end
        if (req.wr && hit_dig) begin
            next_dig_ctrl = req.wdata;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ind_ctrl <= phy_np_pkg::IND_CTRL_RESET;
            dig_ctrl <= phy_np_pkg::DIG_CTRL_RESET;
        end else begin
            ind_ctrl <= next_ind_ctrl;
            dig_ctrl <= next_dig_ctrl;
        end
    end

    assign ext_req = '{
        sel:   ind_ctrl[phy_np_pkg::IND_SEL_MSB:0],
        func:  phy_np_pkg::func_type'(ind_ctrl[phy_np_pkg::IND_FUNC_LSB+1:phy_np_pkg::IND_FUNC_LSB]),
        wr:    req.wr && hit_data,
        rd:    req.rd && hit_data,
        wdata: req.wdata
    };

    ext_register_space u_ext (
        .clk_i   (REF_CLK_I),
        .rst_i   (RST_I),
        .req_i   (ext_req),
        .rdata_o (ext_rdata)
    );

    // Read path and PLL control
    logic [15:0] rd_word;
    logic [15:0] rdata;
    logic        rvalid;
    logic        pll_enable;
    logic [15:0] next_rdata;
    logic        next_rvalid;
    logic        next_pll_enable;

    always_comb begin
        case (req.addr)
            phy_np_pkg::OFS_AN_EXPANSION: rd_word = {14'h0000, page_received, 1'h0};
            phy_np_pkg::OFS_NP_TX:        rd_word = NP_TX_WORD_O;
            phy_np_pkg::OFS_NP_PARTNER:   rd_word = partner;
            phy_np_pkg::OFS_IND_CTRL:     rd_word = ind_ctrl;
            phy_np_pkg::OFS_IND_DATA:     rd_word = ext_rdata;
            phy_np_pkg::OFS_DIG_CTRL:     rd_word = dig_ctrl;
            default:                      rd_word = 16'h0000;
        endcase
        next_rvalid = req.rd;
        next_rdata  = req.rd ? rd_word : rdata;
        // Only in power-down does the option bit matter
        next_pll_enable = !(ENERGY_DETECT_POWER_DOWN_I && dig_ctrl[phy_np_pkg::PLL_OFF_BIT]);
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata      <= phy_np_pkg::RDATA_RESET;
            rvalid     <= phy_np_pkg::RVALID_RESET;
            pll_enable <= phy_np_pkg::PLL_ENABLE_RESET;
        end else begin
            rdata      <= next_rdata;
            rvalid     <= next_rvalid;
            pll_enable <= next_pll_enable;
        end
    end

    assign REG_RDATA_O  = rdata;
    assign REG_RVALID_O = rvalid;
    assign PLL_ENABLE_O = pll_enable;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_read_partner;
        REG_RD_I && !REG_WR_I && REG_ADDR_I == phy_np_pkg::OFS_NP_PARTNER && !PAGE_RX_I;
    endsequence

    chk_comply_write: assert property (
        (REG_WR_I && REG_ADDR_I == phy_np_pkg::OFS_NP_TX)
        |=> (NP_TX_WORD_O[phy_np_pkg::NP_COMPLY_BIT] == $past(REG_WDATA_I[phy_np_pkg::NP_COMPLY_BIT])))
        else $error("compliance bit not written");

    chk_toggle_read: assert property (
        (REG_RD_I && !REG_WR_I && REG_ADDR_I == phy_np_pkg::OFS_NP_TX)
        |=> (REG_RDATA_O[phy_np_pkg::NP_TOGGLE_BIT] == $past(TX_TOGGLE_I, 2)))
        else $error("transmit toggle read wrong");

    chk_msg_field: assert property (
        (REG_WR_I && REG_ADDR_I == phy_np_pkg::OFS_NP_TX)
        |=> (NP_TX_WORD_O[phy_np_pkg::NP_MSG_MSB:0] == $past(REG_WDATA_I[phy_np_pkg::NP_MSG_MSB:0]))
            ##1 $stable(NP_TX_WORD_O[phy_np_pkg::NP_MSG_MSB:0]) || $past(REG_WR_I))
        else $error("message field not held");

    chk_partner_next: assert property (
        PAGE_RX_I ##1 s_read_partner
        |=> (REG_RDATA_O[phy_np_pkg::NP_NEXT_BIT] == $past(PAGE_RX_WORD_I[phy_np_pkg::NP_NEXT_BIT], 2)))
        else $error("partner next-page bit wrong");

    chk_partner_ack: assert property (
        PAGE_RX_I ##1 s_read_partner
        |=> (REG_RDATA_O[phy_np_pkg::NP_ACK_BIT] == $past(PAGE_RX_WORD_I[phy_np_pkg::NP_ACK_BIT], 2)))
        else $error("partner acknowledge bit wrong");

    chk_partner_comply: assert property (
        (PAGE_RX_I ##1 !PAGE_RX_I [*2]) |-> (partner[phy_np_pkg::NP_COMPLY_BIT]
            == $past(PAGE_RX_WORD_I[phy_np_pkg::NP_COMPLY_BIT], 2)))
        else $error("partner compliance bit not held");

    chk_partner_toggle: assert property (
        PAGE_RX_I ##1 s_read_partner
        |=> (REG_RDATA_O[phy_np_pkg::NP_TOGGLE_BIT] == $past(PAGE_RX_WORD_I[phy_np_pkg::NP_TOGGLE_BIT], 2)))
        else $error("partner toggle bit wrong");

    chk_pll_off: assert property (
        (ENERGY_DETECT_POWER_DOWN_I && dig_ctrl[phy_np_pkg::PLL_OFF_BIT]) |=> !PLL_ENABLE_O)
        else $error("PLL not off in power-down");

    chk_pll_on: assert property (
        (!ENERGY_DETECT_POWER_DOWN_I || !dig_ctrl[phy_np_pkg::PLL_OFF_BIT]) |=> PLL_ENABLE_O)
        else $error("PLL off outside power-down option");

    chk_page_latch: assert property (
        PAGE_RX_I |=> page_received ##1 (page_received || $past(REG_RD_I && REG_ADDR_I == phy_np_pkg::OFS_AN_EXPANSION)))
        else $error("page-received flag not latched");

    chk_page_clear: assert property (
        (REG_RD_I && !REG_WR_I && REG_ADDR_I == phy_np_pkg::OFS_AN_EXPANSION && !PAGE_RX_I)
        |=> !page_received)
        else $error("page-received flag not cleared by read");

    chk_read_valid: assert property (
        (REG_RD_I && !REG_WR_I) |=> REG_RVALID_O ##1 (REG_RVALID_O == $past(REG_RD_I && !REG_WR_I)))
        else $error("read answer not one cycle later");

    chk_set_wins: assert property (
        (PAGE_RX_I && REG_RD_I && !REG_WR_I && REG_ADDR_I == phy_np_pkg::OFS_AN_EXPANSION) |=> page_received)
        else $error("page-received flag lost to a coincident read");

    chk_partner_ro: assert property (
        (REG_WR_I && REG_ADDR_I == phy_np_pkg::OFS_NP_PARTNER && !PAGE_RX_I) |=> $stable(partner))
        else $error("partner word changed by a write");

    chk_toggle_ro: assert property (
        (REG_WR_I && REG_ADDR_I == phy_np_pkg::OFS_NP_TX)
        |=> (NP_TX_WORD_O[phy_np_pkg::NP_TOGGLE_BIT] == $past(TX_TOGGLE_I) && !NP_TX_WORD_O[phy_np_pkg::NP_ACK_BIT]))
        else $error("read-only transmit bits followed a write");

    chk_ctrl_write: assert property (
        (REG_WR_I && REG_ADDR_I == phy_np_pkg::OFS_IND_CTRL) |=> (ind_ctrl == $past(REG_WDATA_I)))
        else $error("indirect control not written");

    chk_unmapped_read: assert property (
        (REG_RD_I && !REG_WR_I && REG_ADDR_I == 5'h1F) |=> (REG_RDATA_O == 16'h0000))
        else $error("unmapped offset read nonzero");

    chk_rdata_hold: assert property (
        !(REG_RD_I && !REG_WR_I) |=> $stable(REG_RDATA_O))
        else $error("read data moved without a read");

    cov_page_read: cover property (
        PAGE_RX_I ##[1:4] (REG_RD_I && REG_ADDR_I == phy_np_pkg::OFS_AN_EXPANSION));

    cov_pll_off: cover property (
        ENERGY_DETECT_POWER_DOWN_I && dig_ctrl[phy_np_pkg::PLL_OFF_BIT] ##1 !PLL_ENABLE_O);

    cov_set_clear: cover property (
        PAGE_RX_I && REG_RD_I && REG_ADDR_I == phy_np_pkg::OFS_AN_EXPANSION);

endmodule

// *** verilog/phy_np_pkg.sv ***
// Offsets, field positions, reset values and carriers for the next-page and indirect-access registers
package phy_np_pkg;

    // Register offsets on the management register port
    localparam logic [4:0]  OFS_AN_EXPANSION = 5'h06;
    localparam logic [4:0]  OFS_NP_TX        = 5'h07;
    localparam logic [4:0]  OFS_NP_PARTNER   = 5'h08;
    localparam logic [4:0]  OFS_IND_CTRL     = 5'h0D;
    localparam logic [4:0]  OFS_IND_DATA     = 5'h0E;
    localparam logic [4:0]  OFS_DIG_CTRL     = 5'h10;

    // Field positions
    localparam int          NP_NEXT_BIT      = 15;
    localparam int          NP_ACK_BIT       = 14;
    localparam int          NP_MSG_PAGE_BIT  = 13;
    localparam int          NP_COMPLY_BIT    = 12;
    localparam int          NP_TOGGLE_BIT    = 11;
    localparam int          NP_MSG_MSB       = 10;
    localparam int          PAGE_RX_BIT      = 1;
    localparam int          IND_FUNC_LSB     = 14;
    localparam int          IND_SEL_MSB      = 4;
    localparam int          PLL_OFF_BIT      = 4;

    // Values after reset
    localparam logic        NP_NEXT_RESET     = 1'h0;
    localparam logic        NP_MSG_PAGE_RESET = 1'h1;
    localparam logic        NP_COMPLY_RESET   = 1'h0;
    localparam logic [10:0] NP_MSG_RESET      = 11'h001;
    localparam logic [15:0] PARTNER_RESET     = 16'h0000;
    localparam logic [15:0] IND_CTRL_RESET    = 16'h0000;
    localparam logic [15:0] IND_ADDR_RESET    = 16'h0000;
    localparam logic [15:0] DIG_CTRL_RESET    = 16'h0000;
    localparam logic        TOGGLE_RESET      = 1'h0;
    localparam logic        PAGE_FLAG_RESET   = 1'h0;
    localparam logic        PLL_ENABLE_RESET  = 1'h1;
    localparam logic        RVALID_RESET      = 1'h0;
    localparam logic [15:0] RDATA_RESET       = 16'h0000;
    localparam logic [15:0] STORE_RESET       = 16'h0000;

    // Extended register space storage
    localparam int          NUM_DEV          = 4;
    localparam int          LOC_W            = 4;
    localparam int          DEPTH            = 1 << LOC_W;

    typedef enum logic [1:0] {
        FUNC_ADDR        = 2'h0,
        FUNC_DATA        = 2'h1,
        FUNC_DATA_INC_RW = 2'h2,
        FUNC_DATA_INC_W  = 2'h3
    } func_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic [4:0]  sel;
        func_type    func;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } ext_req_type;

endpackage

// *** verilog/ext_register_space.sv ***
`timescale 1ns/1ps
// Extended register space reached through the indirect address/data register
module ext_register_space (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire phy_np_pkg::ext_req_type  req_i,
    output logic [15:0]                   rdata_o
);
    logic                inc;
    logic [15:0]         dev_rdata [phy_np_pkg::NUM_DEV];

    // Post-increment decode per function mode
    always_comb begin
        inc = 1'h0;
        case (req_i.func)
            phy_np_pkg::FUNC_DATA_INC_RW: inc = req_i.wr || req_i.rd;
            phy_np_pkg::FUNC_DATA_INC_W:  inc = req_i.wr;
            default:                      inc = 1'h0;
        endcase
    end

    for (genvar d = 0; d < phy_np_pkg::NUM_DEV; d++) begin : g_dev
        logic [15:0] addr;
        logic [15:0] next_addr;
        logic [15:0] mem      [phy_np_pkg::DEPTH];
        logic [15:0] next_mem [phy_np_pkg::DEPTH];
        logic        hit;

        assign hit = (req_i.sel == 5'(d));

        // Upper address bits alias onto the small store
        always_comb begin
            next_addr = addr;
            next_mem  = mem;
            if (hit && req_i.func == phy_np_pkg::FUNC_ADDR) begin
                if (req_i.wr) begin
                    next_addr = req_i.wdata;
                end
            end else if (hit) begin
                if (req_i.wr) begin
                    next_mem[addr[phy_np_pkg::LOC_W-1:0]] = req_i.wdata;
                end
                if (inc) begin
                    next_addr = addr + 16'h0001;
                end
            end
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                addr <= phy_np_pkg::IND_ADDR_RESET;
                mem  <= '{default: phy_np_pkg::STORE_RESET};
            end else begin
                addr <= next_addr;
                mem  <= next_mem;
            end
        end

        assign dev_rdata[d] = (req_i.func == phy_np_pkg::FUNC_ADDR) ? addr
                            : mem[addr[phy_np_pkg::LOC_W-1:0]];
    end

    // Unpopulated device selects read zero and drop writes
    assign rdata_o = (req_i.sel < 5'(phy_np_pkg::NUM_DEV)) ? dev_rdata[req_i.sel[1:0]] : 16'h0000;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_inc_rw_read: assert property (
        (req_i.rd && !req_i.wr && req_i.sel == 5'h00 && req_i.func == phy_np_pkg::FUNC_DATA_INC_RW)
        |=> (g_dev[0].addr == $past(g_dev[0].addr) + 16'h0001))
        else $error("address did not advance after read in increment mode");

    chk_inc_w_read: assert property (
        (req_i.rd && !req_i.wr && req_i.sel == 5'h00 && req_i.func == phy_np_pkg::FUNC_DATA_INC_W)
        |=> $stable(g_dev[0].addr))
        else $error("address moved on read in write-only increment mode");

    chk_no_inc_data: assert property (
        ((req_i.wr || req_i.rd) && req_i.sel == 5'h00 && req_i.func == phy_np_pkg::FUNC_DATA)
        |=> $stable(g_dev[0].addr))
        else $error("address moved in plain data mode");

    chk_addr_write: assert property (
        (req_i.wr && req_i.sel == 5'h01 && req_i.func == phy_np_pkg::FUNC_ADDR)
        |=> (g_dev[1].addr == $past(req_i.wdata)))
        else $error("address register missed a write");

    cov_inc_write: cover property (
        (req_i.wr && req_i.func == phy_np_pkg::FUNC_DATA_INC_W) ##1
        (req_i.wr && req_i.func == phy_np_pkg::FUNC_DATA_INC_W));

endmodule

// *** verif/mgmt_station_model.sv ***
`timescale 1ns/1ps
// Behavioural station management controller driving the register port
module mgmt_station_model (
    input  wire logic        clk_i,
    input  wire logic        rvalid_i,
    output logic [4:0]       addr_o,
    output logic [15:0]      wdata_o,
    output logic             wr_o,
    output logic             rd_o
);
    initial begin
        addr_o  = 5'h1F;
        wdata_o = 16'hA5A5;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // Idle bus carries inverted junk so sampling outside a strobe shows up
    task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
        @(posedge clk_i);
        addr_o  <= addr;
        wdata_o <= (addr == phy_np_pkg::OFS_IND_CTRL) ? (data & 16'hC01F) : data;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~addr;
        wdata_o <= ~data;
    endtask

    task automatic read_reg(input logic [4:0] addr, output logic ok);
        int n;
        @(posedge clk_i);
        addr_o <= addr;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~addr;
        ok = 1'b0;
        for (n = 0; n < 4 && !ok; n++) begin
            @(posedge clk_i);
            if (rvalid_i === 1'b1) ok = 1'b1;
        end
    endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the next-page and indirect-access register bank
module tb;
    logic        ref_clk = 1'b0;
    logic        rst;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic        page_rx;
    logic [15:0] page_word;
    logic        tog;
    logic        power_down;
    logic [15:0] np_tx_word;
    logic        pll_en;
    logic [15:0] exp_q[$];
    int          miscompares = 0;
    int          samples_checked = 0;
    logic [15:0] w, e, pw, base, d0, d1;
    int          rnd;

    always #2 ref_clk = ~ref_clk;

    phy_next_page_mmd_regs DUT (
        .REF_CLK_I      (ref_clk),
        .RST_I          (rst),
        .REG_ADDR_I     (reg_addr),
        .REG_WDATA_I    (reg_wdata),
        .REG_WR_I       (reg_wr),
        .REG_RD_I       (reg_rd),
        .REG_RDATA_O    (reg_rdata),
        .REG_RVALID_O   (reg_rvalid),
        .PAGE_RX_I      (page_rx),
        .PAGE_RX_WORD_I (page_word),
        .TX_TOGGLE_I    (tog),
        .ENERGY_DETECT_POWER_DOWN_I (power_down),
        .NP_TX_WORD_O   (np_tx_word),
        .PLL_ENABLE_O   (pll_en)
    );

    mgmt_station_model mgmt (
        .clk_i    (ref_clk),
        .rvalid_i (reg_rvalid),
        .addr_o   (reg_addr),
        .wdata_o  (reg_wdata),
        .wr_o     (reg_wr),
        .rd_o     (reg_rd)
    );

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Oldest note is matched to each read answer
    always @(posedge ref_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, reg_rdata, 16'h0000);
            end else begin
                check(reg_rdata, exp_q.pop_front());
            end
        end
    end

    task automatic rd_chk(input logic [4:0] addr, input logic [15:0] exp);
        logic ok;
        exp_q.push_back(exp);
        mgmt.read_reg(addr, ok);
        check({15'h0000, ok}, 16'h0001);
    endtask

    // Reserved control bits offered as ones; the station clears them
    task automatic set_fn(input phy_np_pkg::func_type f, input logic [4:0] dev);
        mgmt.write_reg(phy_np_pkg::OFS_IND_CTRL, {f, 9'h1FF, dev});
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
    endtask

    initial begin
        #200000;
        miscompares++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        rst       = 1'b1;
        page_rx   = 1'b0;
        page_word = 16'h0000;
        tog       = 1'b0;
        power_down = 1'b0;
        rnd       = $urandom(38265);
        do_reset();
        rd_chk(phy_np_pkg::OFS_NP_TX, 16'h2001);
        rd_chk(phy_np_pkg::OFS_NP_PARTNER, 16'h0000);
        rd_chk(phy_np_pkg::OFS_IND_CTRL, 16'h0000);
        rd_chk(phy_np_pkg::OFS_DIG_CTRL, 16'h0000);
        rd_chk(phy_np_pkg::OFS_AN_EXPANSION, 16'h0000);
        rd_chk(5'h1F, 16'h0000);
        check({15'h0000, pll_en}, 16'h0001);
        $display("test reset_values done");

        for (int i = 0; i < 4; i++) begin
            tog <= i[0];
            w = (i == 0) ? 16'hFFFF : 16'($urandom);
            e = (w & 16'hB7FF) | {4'h0, i[0], 11'h000};
            mgmt.write_reg(phy_np_pkg::OFS_NP_TX, w);
            rd_chk(phy_np_pkg::OFS_NP_TX, e);
            check(np_tx_word, e);
        end
        $display("test transmit_word done");

        for (int i = 0; i < 3; i++) begin
            pw = (i == 0) ? 16'hD800 : (i == 1) ? 16'h0000 : 16'($urandom);
            @(posedge ref_clk);
            page_rx   <= 1'b1;
            page_word <= pw;
            // Read lands the cycle after the page pulse
            fork
                begin
                    @(posedge ref_clk);
                    page_rx   <= 1'b0;
                    page_word <= ~pw;
                end
                rd_chk(phy_np_pkg::OFS_NP_PARTNER, pw);
            join
            mgmt.write_reg(phy_np_pkg::OFS_NP_PARTNER, ~pw);
            rd_chk(phy_np_pkg::OFS_NP_PARTNER, pw);
            rd_chk(phy_np_pkg::OFS_AN_EXPANSION, 16'h0002);
            rd_chk(phy_np_pkg::OFS_AN_EXPANSION, 16'h0000);
        end
        // Page pulse and flag read in one cycle: the set wins
        fork
            begin
                @(posedge ref_clk);
                page_rx <= 1'b1;
                @(posedge ref_clk);
                page_rx <= 1'b0;
            end
            rd_chk(phy_np_pkg::OFS_AN_EXPANSION, 16'h0000);
        join
        rd_chk(phy_np_pkg::OFS_AN_EXPANSION, 16'h0002);
        $display("test partner_page done");

        for (int dev = 0; dev < 4; dev++) begin
            base = 16'($urandom_range(13, 0));
            d0   = 16'($urandom);
            d1   = 16'($urandom);
            set_fn(phy_np_pkg::FUNC_ADDR, 5'(dev));
            rd_chk(phy_np_pkg::OFS_IND_CTRL, {11'h000, 5'(dev)});
            mgmt.write_reg(phy_np_pkg::OFS_IND_DATA, base);
            rd_chk(phy_np_pkg::OFS_IND_DATA, base);
            set_fn(phy_np_pkg::FUNC_DATA_INC_W, 5'(dev));
            mgmt.write_reg(phy_np_pkg::OFS_IND_DATA, d0);
            mgmt.write_reg(phy_np_pkg::OFS_IND_DATA, d1);
            rd_chk(phy_np_pkg::OFS_IND_DATA, 16'h0000);
            set_fn(phy_np_pkg::FUNC_ADDR, 5'(dev));
            rd_chk(phy_np_pkg::OFS_IND_DATA, base + 16'h0002);
            mgmt.write_reg(phy_np_pkg::OFS_IND_DATA, base);
            set_fn(phy_np_pkg::FUNC_DATA, 5'(dev));
            rd_chk(phy_np_pkg::OFS_IND_DATA, d0);
            rd_chk(phy_np_pkg::OFS_IND_DATA, d0);
            set_fn(phy_np_pkg::FUNC_DATA_INC_RW, 5'(dev));
            rd_chk(phy_np_pkg::OFS_IND_DATA, d0);
            rd_chk(phy_np_pkg::OFS_IND_DATA, d1);
            set_fn(phy_np_pkg::FUNC_ADDR, 5'(dev));
            rd_chk(phy_np_pkg::OFS_IND_DATA, base + 16'h0002);
        end
        set_fn(phy_np_pkg::FUNC_DATA, 5'h04);
        rd_chk(phy_np_pkg::OFS_IND_DATA, 16'h0000);
        $display("test indirect_access done");

        for (int i = 0; i < 4; i++) begin
            power_down <= i[0];
            w = (16'($urandom) & 16'hFFEF) | {11'h000, i[1], 4'h0};
            mgmt.write_reg(phy_np_pkg::OFS_DIG_CTRL, w);
            rd_chk(phy_np_pkg::OFS_DIG_CTRL, w);
            check({15'h0000, pll_en}, {15'h0000, ~(i[0] & i[1])});
        end
        $display("test pll_control done");

        // Reset in mid-run, with power-down still requested
        tog <= 1'b1;
        do_reset();
        rd_chk(phy_np_pkg::OFS_NP_TX, 16'h2801);
        check({15'h0000, pll_en}, 16'h0001);
        $display("test second_reset done");
        // Let the monitor take the last answer before the verdict
        @(posedge ref_clk);
        tally_and_finish();
    end
endmodule
